// ---- port_ctl_if.sv ----
// requests and state between the register side and the port state machine
`timescale 1ns/100ps
`default_nettype none

interface port_ctl_if;
  logic ce;
  logic power;
  logic sw_reset;
  logic sw_disable;
  logic sw_suspend;
  logic sw_resume;
  logic sw_resume_end;
  logic disconnect;
  logic eof2_error;
  logic k_edge;
  logic hs_detect;
  logic enabled;
  logic resume_flag;
  logic suspended;
  logic resuming;
  logic in_reset;
  logic err_disable;
  logic remote_wake;

  modport ctrl (
    output ce, power, sw_reset, sw_disable, sw_suspend, sw_resume, sw_resume_end,
    output disconnect, eof2_error, k_edge, hs_detect,
    input  enabled, resume_flag, suspended, resuming, in_reset, err_disable, remote_wake
  );

  modport fsm (
    input  ce, power, sw_reset, sw_disable, sw_suspend, sw_resume, sw_resume_end,
    input  disconnect, eof2_error, k_edge, hs_detect,
    output enabled, resume_flag, suspended, resuming, in_reset, err_disable, remote_wake
  );
endinterface : port_ctl_if

`default_nettype wire

// ---- port_state_fsm.sv ----
// port state machine: reset, enable, suspend, resume and return to hs idle
`timescale 1ns/100ps
`default_nettype none
`include "usb_root_port_map.svh"

module port_state_fsm #(
  parameter int unsigned PORT_RESET_CYCLES = `PORT_RESET_CYC
) (
  input wire logic    pclk,
  input wire logic    presetn,
  port_ctl_if.fsm     pc
);
  import usb_root_port_pkg::*;

  localparam logic [21:0] RST_LAST     = 22'(PORT_RESET_CYCLES - 1);
  localparam logic [21:0] RESTORE_LAST = 22'(`HS_RESTORE_CYC - 1);

  port_state_t state_q, state_d;
  logic [21:0] cnt_q, cnt_d;
  logic        err_q, err_d;
  logic        wake_q, wake_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    err_d   = 1'b0;
    wake_d  = 1'b0;
    if (!pc.power) begin
      state_d = PS_DISABLED;
      cnt_d   = '0;
    end else if (pc.disconnect && state_q != PS_DISABLED && state_q != PS_RESETTING) begin
      state_d = PS_DISABLED;
    end else begin
      unique case (state_q)
        PS_DISABLED: begin
          if (pc.sw_reset) begin
            state_d = PS_RESETTING;
            cnt_d   = '0;
          end
        end
        PS_RESETTING: begin
          if (cnt_q == RST_LAST) begin
            state_d = pc.hs_detect ? PS_ENABLED : PS_DISABLED;
          end else begin
            cnt_d = cnt_q + 22'h000001;
          end
        end
        PS_ENABLED: begin
          if (pc.eof2_error) begin
            state_d = PS_DISABLED;
            err_d   = 1'b1;
          end else if (pc.sw_disable) begin
            state_d = PS_DISABLED;
          end else if (pc.sw_reset) begin
            state_d = PS_RESETTING;
            cnt_d   = '0;
          end else if (pc.sw_suspend) begin
            state_d = PS_SUSPENDED;
          end
        end
        PS_SUSPENDED: begin
          if (pc.sw_disable) begin
            state_d = PS_DISABLED;
          end else if (pc.sw_reset) begin
            state_d = PS_RESETTING;
            cnt_d   = '0;
          end else if (pc.k_edge) begin
            state_d = PS_RESUMING;
            wake_d  = 1'b1;
          end else if (pc.sw_resume) begin
            state_d = PS_RESUMING;
          end
        end
        PS_RESUMING: begin
          if (pc.sw_disable) begin
            state_d = PS_DISABLED;
          end else if (pc.sw_resume_end) begin
            state_d = PS_RESTORING;
            cnt_d   = '0;
          end
        end
        PS_RESTORING: begin
          if (cnt_q == RESTORE_LAST) begin
            state_d = PS_ENABLED;
          end else begin
            cnt_d = cnt_q + 22'h000001;
          end
        end
        default: begin
          state_d = PS_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PS_DISABLED;
      cnt_q   <= '0;
      err_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else if (pc.ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      err_q   <= err_d;
      wake_q  <= wake_d;
    end
  end

  // bits follow the actual port state
  assign pc.enabled     = state_q inside {PS_ENABLED, PS_SUSPENDED, PS_RESUMING, PS_RESTORING};
  assign pc.resume_flag = state_q inside {PS_RESUMING, PS_RESTORING};
  assign pc.suspended   = state_q inside {PS_SUSPENDED, PS_RESUMING, PS_RESTORING};
  assign pc.resuming    = state_q == PS_RESUMING;
  assign pc.in_reset    = state_q == PS_RESETTING;
  assign pc.err_disable = err_q;
  assign pc.remote_wake = wake_q;
endmodule : port_state_fsm

`default_nettype wire

// ---- usb_hs_device_model.sv ----
// downstream high-speed device on the root port
`timescale 1ns/100ps
`default_nettype none

module usb_hs_device_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic attach,
  input  wire logic hs_capable,
  input  wire logic wake,
  input  wire logic oc_fault,
  input  wire logic line_err,
  input  wire logic port_reset_drive,
  input  wire logic resume_k_drive,
  output wire logic connect_pin,
  output wire logic hs_chirp_pin,
  output wire logic line_k_pin,
  output wire logic overcurrent_pin,
  output wire logic port_error_pin
);
  logic chirp_q, chirp_d;

  // chirp answer kept until unplugged
  always_comb begin
    chirp_d = chirp_q;
    if (!attach) begin
      chirp_d = 1'b0;
    end else if (port_reset_drive && hs_capable) begin
      chirp_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chirp_q <= 1'b0;
    end else begin
      chirp_q <= chirp_d;
    end
  end

  assign connect_pin = attach;
  assign hs_chirp_pin = chirp_q;
  assign line_k_pin = attach & (wake | resume_k_drive);
  assign overcurrent_pin = oc_fault;
  assign port_error_pin = line_err;
endmodule : usb_hs_device_model

`default_nettype wire

// ---- usb_root_port_map.svh ----
// register offsets, field positions, reset values and timing counts of the root port
`ifndef USB_ROOT_PORT_MAP_SVH
`define USB_ROOT_PORT_MAP_SVH

`define PORT_SC_OFF        12'h000
`define HOST_STS_OFF       12'h004

`define PSC_CONNECT_BIT    0
`define PSC_ENABLED_BIT    2
`define PSC_ENCHG_BIT      3
`define PSC_OCACT_BIT      4
`define PSC_OCCHG_BIT      5
`define PSC_RESUME_BIT     6
`define PSC_SUSPEND_BIT    7
`define PSC_RESET_BIT      8
`define PSC_POWER_BIT      12
`define HSTS_PCD_BIT       2

`define PORT_SC_RST        32'h0000_0000
`define HOST_STS_RST       32'h0000_0000

`define CLK_KHZ            50000
`define PORT_RESET_MS      50
`define PORT_RESET_CYC     (`PORT_RESET_MS * `CLK_KHZ)
`define HS_IDLE_LIMIT_MS   2
`define HS_RESTORE_US      20
`define HS_RESTORE_CYC     ((`HS_RESTORE_US * `CLK_KHZ) / 1000)

`endif

// ---- usb_root_port_pkg.sv ----
// types shared by the root port status and control logic
package usb_root_port_pkg;

  typedef logic [11:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;

  typedef enum logic [2:0] {
    PS_DISABLED,
    PS_RESETTING,
    PS_ENABLED,
    PS_SUSPENDED,
    PS_RESUMING,
    PS_RESTORING
  } port_state_t;

endpackage : usb_root_port_pkg

// ---- usb_root_port_status_control.sv ----
// root hub port status and control with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "usb_root_port_map.svh"

module usb_root_port_status_control #(
  parameter int unsigned PORT_RESET_CYCLES = `PORT_RESET_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire usb_root_port_pkg::apb_addr_t paddr,
  input  wire usb_root_port_pkg::apb_data_t pwdata,
  output var  usb_root_port_pkg::apb_data_t prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire logic                       connect_pin,
  input  wire logic                       overcurrent_pin,
  input  wire logic                       line_k_pin,
  input  wire logic                       hs_chirp_pin,
  input  wire logic                       port_error_pin,
  input  wire logic                       frame_eof2,
  output var  logic                       downstream_enable,
  output var  logic                       port_reset_drive,
  output var  logic                       resume_k_drive,
  output var  logic                       port_power_on
);
  import usb_root_port_pkg::*;

  localparam int unsigned NPIN = 5;
  localparam int unsigned P_CONN = 0;
  localparam int unsigned P_OC   = 1;
  localparam int unsigned P_K    = 2;
  localparam int unsigned P_HS   = 3;
  localparam int unsigned P_ERR  = 4;

  function automatic logic reg_hit(input apb_addr_t a, input apb_addr_t off);
    reg_hit = (a[11:2] == off[11:2]);
  endfunction : reg_hit

  port_ctl_if pc ();

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [NPIN-1:0] pins_in;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;

  assign pins_in = {port_error_pin, hs_chirp_pin, line_k_pin, overcurrent_pin, connect_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (ce) begin
          sync1_q[gi] <= pins_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // line event detection
  // ---------------------------------------------------------------------
  logic conn_q, conn_d;
  logic k_prev_q, k_prev_d;
  logic ocact_q, ocact_d;
  logic disconnect_evt;
  logic k_edge_evt;
  logic ocact_change;

  always_comb begin
    conn_d   = sync2_q[P_CONN];
    k_prev_d = sync2_q[P_K];
    ocact_d  = sync2_q[P_OC];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_q   <= 1'b0;
      k_prev_q <= 1'b0;
      ocact_q  <= 1'b0;
    end else if (ce) begin
      conn_q   <= conn_d;
      k_prev_q <= k_prev_d;
      ocact_q  <= ocact_d;
    end
  end

  assign disconnect_evt = conn_q & ~sync2_q[P_CONN];
  // j to k: line leaves j and shows k
  assign k_edge_evt     = sync2_q[P_K] & ~k_prev_q;
  assign ocact_change   = sync2_q[P_OC] ^ ocact_q;

  // ---------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------
  logic      setup_ph;
  logic      access_ph;
  logic      mapped;
  logic      wr_sc;
  logic      wr_hs;
  apb_data_t sc_rd;
  apb_data_t hs_rd;
  apb_data_t rd_mux;
  apb_data_t prdata_q, prdata_d;
  logic      pready_q, pready_d;
  logic      pslverr_q, pslverr_d;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & pready_q;
  assign mapped    = reg_hit(paddr, `PORT_SC_OFF) | reg_hit(paddr, `HOST_STS_OFF);
  assign wr_sc     = access_ph & pwrite & reg_hit(paddr, `PORT_SC_OFF);
  assign wr_hs     = access_ph & pwrite & reg_hit(paddr, `HOST_STS_OFF);

  always_comb begin
    if (reg_hit(paddr, `PORT_SC_OFF)) begin
      rd_mux = sc_rd;
    end else if (reg_hit(paddr, `HOST_STS_OFF)) begin
      rd_mux = hs_rd;
    end else begin
      rd_mux = '0;
    end
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~mapped;
    prdata_d  = prdata_q;
    if (setup_ph) begin
      prdata_d = pwrite ? '0 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------
  // status flags and port power
  // ---------------------------------------------------------------------
  logic power_q, power_d;
  logic enchg_q, enchg_d;
  logic occhg_q, occhg_d;
  logic pcd_q, pcd_d;
  logic enchg_clr;
  logic occhg_clr;
  logic pcd_clr;

  // a zero written to a change flag is no clear
  assign enchg_clr = wr_sc & pwdata[`PSC_ENCHG_BIT];
  assign occhg_clr = wr_sc & pwdata[`PSC_OCCHG_BIT];
  assign pcd_clr  = wr_hs & pwdata[`HSTS_PCD_BIT];

  always_comb begin
    power_d = power_q;
    if (wr_sc) begin
      power_d = pwdata[`PSC_POWER_BIT];
    end
    // set wins over a clear in the same cycle
    enchg_d = power_q & ((enchg_q & ~enchg_clr) | pc.err_disable);
    occhg_d = (occhg_q & ~occhg_clr) | ocact_change;
    pcd_d  = (pcd_q & ~pcd_clr) | pc.remote_wake;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= 1'(`PORT_SC_RST >> `PSC_POWER_BIT);
      enchg_q <= 1'b0;
      occhg_q <= 1'b0;
      pcd_q   <= 1'b0;
    end else if (ce) begin
      power_q <= power_d;
      enchg_q <= enchg_d;
      occhg_q <= occhg_d;
      pcd_q   <= pcd_d;
    end
  end

  // ---------------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------------
  always_comb begin
    sc_rd                   = '0;
    sc_rd[`PSC_CONNECT_BIT] = conn_q;
    sc_rd[`PSC_ENABLED_BIT] = pc.enabled & power_q;
    sc_rd[`PSC_ENCHG_BIT]   = enchg_q & power_q;
    sc_rd[`PSC_OCACT_BIT]   = ocact_q;
    sc_rd[`PSC_OCCHG_BIT]   = occhg_q;
    sc_rd[`PSC_RESUME_BIT]  = pc.resume_flag & power_q;
    sc_rd[`PSC_SUSPEND_BIT] = pc.suspended & power_q;
    sc_rd[`PSC_RESET_BIT]   = pc.in_reset;
    sc_rd[`PSC_POWER_BIT]   = power_q;
    hs_rd                   = '0;
    hs_rd[`HSTS_PCD_BIT]    = pcd_q;
  end

  // ---------------------------------------------------------------------
  // requests to the port state machine
  // ---------------------------------------------------------------------
  assign pc.ce            = ce;
  assign pc.power         = power_q;
  // a written 1 in the enabled field is ignored
  assign pc.sw_disable    = wr_sc & ~pwdata[`PSC_ENABLED_BIT] & pc.enabled;
  assign pc.sw_reset      = wr_sc & pwdata[`PSC_RESET_BIT] & ~pc.in_reset & power_q;
  assign pc.sw_suspend    = wr_sc & pwdata[`PSC_SUSPEND_BIT] & ~pc.suspended;
  assign pc.sw_resume     = wr_sc & pwdata[`PSC_RESUME_BIT] & ~pc.resume_flag;
  assign pc.sw_resume_end = wr_sc & ~pwdata[`PSC_RESUME_BIT] & pc.resuming;
  assign pc.disconnect    = disconnect_evt;
  assign pc.eof2_error    = frame_eof2 & sync2_q[P_ERR];
  assign pc.k_edge        = k_edge_evt;
  assign pc.hs_detect     = sync2_q[P_HS];

  port_state_fsm #(
    .PORT_RESET_CYCLES (PORT_RESET_CYCLES)
  ) u_fsm (
    .pclk    (pclk),
    .presetn (presetn),
    .pc      (pc.fsm)
  );

  // ---------------------------------------------------------------------
  // line drive outputs
  // ---------------------------------------------------------------------
  logic dsen_q, dsen_d;
  logic prst_q, prst_d;
  logic rsmk_q, rsmk_d;

  always_comb begin
    dsen_d = pc.enabled & power_q;
    prst_d = pc.in_reset & power_q;
    rsmk_d = pc.resuming & power_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsen_q <= 1'b0;
      prst_q <= 1'b0;
      rsmk_q <= 1'b0;
    end else if (ce) begin
      dsen_q <= dsen_d;
      prst_q <= prst_d;
      rsmk_q <= rsmk_d;
    end
  end

  assign downstream_enable = dsen_q;
  assign port_reset_drive  = prst_q;
  assign resume_k_drive    = rsmk_q;
  assign port_power_on     = power_q;
endmodule : usb_root_port_status_control

`default_nettype wire

// ---- usb_root_port_status_control_checker.sv ----
// assertions on the root port pins and the apb answer
`timescale 1ns/100ps
`default_nettype none
`include "usb_root_port_map.svh"

module usb_root_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic connect_pin,
  input wire logic hs_chirp_pin,
  input wire logic port_error_pin,
  input wire logic frame_eof2,
  input wire logic downstream_enable,
  input wire logic port_reset_drive,
  input wire logic resume_k_drive,
  input wire logic port_power_on
);
  localparam int LIMIT_CYC = `HS_IDLE_LIMIT_MS * `CLK_KHZ;
  logic [16:0] rest_q, rest_d;
  logic [3:0]  age_q, age_d;
  logic        rk_q;

  // age since reset signalling, and cycles spent returning to hs idle
  always_comb begin
    age_d = port_reset_drive ? 4'h0 : ((age_q == 4'hF) ? age_q : age_q + 4'h1);
    rest_d = rest_q;
    if (rest_q != 17'h0) begin
      rest_d = (downstream_enable || !port_power_on) ? 17'h0 : rest_q + 17'h1;
    end
    if (rk_q && !resume_k_drive) begin
      rest_d = 17'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 4'hF;
      rest_q <= 17'h0;
      rk_q <= 1'b0;
    end else begin
      age_q <= age_d;
      rest_q <= rest_d;
      rk_q <= resume_k_drive;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_err_frame;
    port_error_pin[*4] ##0 (frame_eof2 && downstream_enable);
  endsequence
  sequence s_unplug;
    (connect_pin && downstream_enable) ##1 !connect_pin;
  endsequence

  a_ready_first: assert property (s_setup ##1 ce |-> pready)
    else $error("no ready in first access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_power_gates: assert property ((!port_power_on)[*3] |-> !downstream_enable && !resume_k_drive)
    else $error("port active without power");
  a_reset_blocks: assert property (port_reset_drive |-> !downstream_enable)
    else $error("data enabled during reset");
  a_enable_cause: assert property ($rose(downstream_enable) |-> (age_q < 4'h6 && hs_chirp_pin) || rest_q != 17'h0)
    else $error("port enabled without hs reset");
  a_unplug_off: assert property (s_unplug |-> ##[1:8] !downstream_enable)
    else $error("port still enabled after disconnect");
  a_eof2_off: assert property (s_err_frame |-> ##[1:6] !downstream_enable)
    else $error("port still enabled after frame error");
  a_idle_limit: assert property (rest_q < LIMIT_CYC)
    else $error("hs idle not reached in time");
endmodule : usb_root_port_checker

bind usb_root_port_status_control usb_root_port_checker chk_i (.pclk, .presetn, .ce, .psel,
  .penable, .pready, .pslverr, .connect_pin, .hs_chirp_pin, .port_error_pin, .frame_eof2,
  .downstream_enable, .port_reset_drive, .resume_k_drive, .port_power_on);

`default_nettype wire

// ---- usb_root_port_status_control_tb_top.sv ----
// self-checking bench for the root port status and control block
`timescale 1ns/100ps
`default_nettype none
`include "usb_root_port_map.svh"

module usb_root_port_status_control_tb_top;
  import usb_root_port_pkg::*;
  localparam int unsigned RST_CYC = 20;
  localparam apb_addr_t SC = `PORT_SC_OFF;
  localparam apb_addr_t HS = `HOST_STS_OFF;
  localparam apb_data_t PCD = 32'h1 << `HSTS_PCD_BIT;
  localparam apb_data_t B_CON = 32'h1;
  localparam apb_data_t B_EN = 32'h4;
  localparam apb_data_t B_ENC = 32'h8;
  localparam apb_data_t B_OCA = 32'h10;
  localparam apb_data_t B_OCC = 32'h20;
  localparam apb_data_t B_RES = 32'h40;
  localparam apb_data_t B_SUS = 32'h80;
  localparam apb_data_t B_RST = 32'h100;
  localparam apb_data_t B_PWR = 32'h1000;
  localparam apb_data_t BASE = B_CON | B_PWR | B_EN;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, frame_eof2;
  apb_addr_t   paddr;
  apb_data_t   pwdata, prdata;
  logic        connect_pin, overcurrent_pin, line_k_pin, hs_chirp_pin, port_error_pin;
  logic        downstream_enable, port_reset_drive, resume_k_drive, port_power_on;
  logic        attach, hs_capable, wake, oc_fault, line_err;
  int          n_mismatch, n_checks, seed;
  logic [32:0] exp_q[$];

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  usb_root_port_status_control #(.PORT_RESET_CYCLES(RST_CYC)) dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .connect_pin, .overcurrent_pin, .line_k_pin, .hs_chirp_pin, .port_error_pin,
    .frame_eof2, .downstream_enable, .port_reset_drive, .resume_k_drive, .port_power_on
  );

  usb_hs_device_model dev (
    .pclk, .presetn, .attach, .hs_capable, .wake, .oc_fault, .line_err, .port_reset_drive,
    .resume_k_drive, .connect_pin, .hs_chirp_pin, .line_k_pin, .overcurrent_pin, .port_error_pin
  );

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic apb(input logic wr, input apb_addr_t a, input apb_data_t d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      n_mismatch++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input apb_addr_t a, input apb_data_t e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic reset_port(input logic hs);
    hs_capable <= hs;
    apb(1'b1, SC, B_PWR | B_EN | B_RST);
    idle(RST_CYC + 12);
  endtask : reset_port

  // read answers are matched in order of request
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("read word", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    seed = 54742;
    n_mismatch = 0;
    n_checks = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    frame_eof2 = 1'b0;
    attach = 1'b1;
    hs_capable = 1'b0;
    wake = 1'b0;
    oc_fault = 1'b0;
    line_err = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle(6);
    rd(SC, B_CON);
    apb(1'b1, SC, B_PWR | B_EN);
    rd(SC, B_CON | B_PWR);
    reset_port(1'b0);
    rd(SC, B_CON | B_PWR);
    reset_port(1'b1);
    rd(SC, BASE);
    chk("downstream_enable", {32'h0, downstream_enable}, 33'h1);
    oc_fault <= 1'b1;
    idle(8);
    rd(SC, BASE | B_OCA | B_OCC);
    apb(1'b1, SC, BASE);
    rd(SC, BASE | B_OCA | B_OCC);
    apb(1'b1, SC, BASE | B_OCC);
    rd(SC, BASE | B_OCA);
    oc_fault <= 1'b0;
    idle(8);
    rd(SC, BASE | B_OCC);
    apb(1'b1, SC, BASE | B_OCC | B_ENC);
    rd(SC, BASE);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, HS, PCD);
      apb(1'b1, SC, BASE | B_SUS);
      rd(SC, BASE | B_SUS);
      if (k == 0) begin
        apb(1'b1, SC, BASE | B_RES);
      end else begin
        wake <= 1'b1;
      end
      idle(8);
      wake <= 1'b0;
      chk("resume_k_drive", {32'h0, resume_k_drive}, 33'h1);
      rd(SC, BASE | B_SUS | B_RES);
      rd(HS, 32'(k) << `HSTS_PCD_BIT);
      apb(1'b1, HS, PCD);
      apb(1'b1, SC, BASE);
      rd(SC, BASE | B_SUS | B_RES);
      idle(`HS_RESTORE_CYC + 10);
      rd(SC, BASE);
      rd(HS, 32'h0);
    end
    for (int e = 0; e < 2; e++) begin
      line_err <= e[0];
      idle(5);
      frame_eof2 <= 1'b1;
      @(posedge pclk);
      frame_eof2 <= 1'b0;
      idle(8);
      rd(SC, (e != 0) ? (B_CON | B_PWR | B_ENC) : BASE);
    end
    chk("downstream_enable", {32'h0, downstream_enable}, 33'h0);
    line_err <= 1'b0;
    apb(1'b1, SC, B_PWR | B_ENC);
    rd(SC, B_CON | B_PWR);
    reset_port(1'b1);
    attach <= 1'b0;
    idle(8);
    rd(SC, B_PWR);
    attach <= 1'b1;
    reset_port(1'b1);
    apb(1'b1, SC, B_PWR);
    rd(SC, B_CON | B_PWR);
    reset_port(1'b1);
    apb(1'b1, SC, B_EN);
    rd(SC, B_CON);
    chk("port_power_on", {32'h0, port_power_on}, 33'h0);
    apb(1'b1, 12'h008, $random(seed));
    rd(12'h008, 32'h0, 1'b1);
    rd(SC, B_CON);
    idle(4);
    report_and_stop();
  end
endmodule : usb_root_port_status_control_tb_top

`default_nettype wire
